//--- pkg/keypad_mode_map.svh
/*
 Constants of the keypad operation mode controller: menu numbers,
 menu-limit values, running information items per alarm and display alternation timing.
 Assumes a 250 MHz system clock.
*/
`ifndef KEYPAD_MODE_MAP_SVH
`define KEYPAD_MODE_MAP_SVH

// Menu numbers shown in the leftmost digit
`define KP_MENU_FIRST 3'h1
`define KP_MENU_CHECK 3'h2
`define KP_MENU_ALARM 3'h6
`define KP_MENU_COPY 3'h7

// Menu-limit setting values
`define KP_LIMIT_SET 2'h0
`define KP_LIMIT_CHECK 2'h1
`define KP_LIMIT_FULL 2'h2

// Reset values
`define KP_MENU_RESET 3'h1
`define KP_IDX_RESET 2'h0

// Number of running information items kept per alarm
`define KP_INFO_ITEMS 3'h4

// Item number / data alternation on the display
`define KP_CLK_PERIOD_NS 4
`define KP_ALT_TIME_NS 500000000
`define KP_ALT_CYCLES (`KP_ALT_TIME_NS / `KP_CLK_PERIOD_NS)

`endif

//--- pkg/keypad_mode_pkg.sv
/*
 Types of the keypad operation mode controller: operation modes,
 display selections and controller states.
 Assumes nothing of its surroundings.
*/
package keypad_mode_pkg;

	// The three operation modes
	typedef enum logic [1:0] {
		MODE_RUNNING,
		MODE_PROGRAM,
		MODE_ALARM
	} opMode_e;

	// What the four-digit display is asked to show
	typedef enum logic [2:0] {
		DISP_RUNNING,
		DISP_MENU,
		DISP_ALARM_CODE,
		DISP_INFO_NUM,
		DISP_INFO_DATA,
		DISP_HIST_CODE
	} dispSel_e;

	// Controller states
	typedef enum logic [2:0] {
		ST_RUNNING,
		ST_PROG_MENU,
		ST_PROG_HIST,
		ST_ALARM_CODE,
		ST_ALARM_INFO
	} state_e;

endpackage

//--- pkg/alarm_hist_if.sv
/*
 Link between the mode controller and its alarm history store.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface alarm_hist_if;
	logic wrEn;
	logic [7:0] wrCode;
	logic [63:0] wrInfo;
	logic [1:0] rdAge;
	logic [7:0] rdCode;
	logic [63:0] rdInfo;

	// Controller side writes alarms and picks the age to read
	modport ctrl (
		output wrEn, wrCode, wrInfo, rdAge,
		input rdCode, rdInfo
	);

	// Store side
	modport store (
		input wrEn, wrCode, wrInfo, rdAge,
		output rdCode, rdInfo
	);
endinterface

//--- hdl/alarm_history_mem.sv
/*
 Alarm history store: the active alarm and the three before it, each
 with its running information snapshot. Read data are registered.
 Assumes one write per alarm and a free-running clock enable.
*/
`timescale 1ns/1ns
module alarm_history_mem (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	// Controller link
	alarm_hist_if.store hist
);

	logic [71:0] entry_ff [4];
	logic [1:0] head_ff;
	logic [1:0] slot;
	logic [7:0] rdCode_ff;
	logic [63:0] rdInfo_ff;

	// Age 0 is the newest entry; older ones sit behind the head
	assign slot = head_ff - hist.rdAge;

	// Circular write, the oldest entry is overwritten
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			head_ff <= 2'h3;
			for (int i = 0; i < 4; i++) begin
				entry_ff[i] <= 72'h0;
			end
		end else if (clkEn && hist.wrEn) begin
			head_ff <= head_ff + 2'h1;
			entry_ff[head_ff + 2'h1] <= {hist.wrCode, hist.wrInfo};
		end
	end

	// Registered read port
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdCode_ff <= 8'h00;
			rdInfo_ff <= 64'h0;
		end else if (clkEn) begin
			rdCode_ff <= entry_ff[slot][71:64];
			rdInfo_ff <= entry_ff[slot][63:0];
		end
	end

	assign hist.rdCode = rdCode_ff;
	assign hist.rdInfo = rdInfo_ff;

endmodule // alarm_history_mem

//--- hdl/keypad_operation_mode_fsm.sv
/*
 Operation mode controller of the motor inverter keypad: Running,
 Programming and Alarm modes, menu stepping under the menu limit, alarm
 release, history browsing and running information at the alarm.
 Assumes key inputs are one-cycle press pulses synchronous to clk,
 stopKeyHeld is a level, and alarmRaise is a one-cycle pulse.
*/
`timescale 1ns/1ns
`include "keypad_mode_map.svh"

module keypad_operation_mode_fsm #(
	parameter int unsigned ALT_CYCLES = `KP_ALT_CYCLES
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	// Keypad keys
	input wire logic programResetKey,
	input wire logic functionDataKey,
	input wire logic upKey,
	input wire logic downKey,
	input wire logic stopKeyHeld,
	// Protective function
	input wire logic alarmRaise,
	input wire logic [7:0] alarmCode,
	input wire logic alarmCauseActive,
	input wire logic [63:0] runInfoSnap,
	// Configuration
	input wire logic [1:0] menuLimitSetting,
	input wire logic remoteKeypadReady,
	// Display selection
	output keypad_mode_pkg::opMode_e opMode,
	output keypad_mode_pkg::dispSel_e dispSel,
	output logic [2:0] menuNumber,
	output logic [1:0] alarmIndex,
	output logic [1:0] infoItem,
	output logic [15:0] dispData,
	output logic changedOnly,
	// Alarm control
	output logic alarmPending,
	output logic alarmRelease
);

	keypad_mode_pkg::state_e state_ff, nxt_state;
	keypad_mode_pkg::opMode_e opMode_ff;
	keypad_mode_pkg::dispSel_e dispSel_ff, selNow;
	logic [2:0] menu_ff;
	logic [1:0] alarmIdx_ff;
	logic [1:0] infoItem_ff;
	logic alarmActive_ff;
	logic alarmRelease_ff;
	logic releaseHit;
	logic [31:0] altCnt_ff;
	logic showData_ff;
	logic altRun;
	logic [15:0] dispData_ff;
	logic changedOnly_ff;
	logic combo;
	logic enterProg;
	alarm_hist_if hist ();

	// Menu selectable under the limit; menu seven needs the remote keypad
	function automatic logic menuAllowed(input logic [2:0] m, input logic [1:0] lim, input logic rem);
		logic ok;
		ok = 1'b0;
		if (lim == `KP_LIMIT_FULL) begin
			ok = (m >= `KP_MENU_FIRST && m <= `KP_MENU_ALARM) || (rem && m == `KP_MENU_COPY);
		end else if (lim == `KP_LIMIT_CHECK) begin
			ok = (m == `KP_MENU_CHECK);
		end else begin
			ok = (m == `KP_MENU_FIRST);
		end
		return ok;
	endfunction

	// Step to the next selectable menu, wrapping over the seven numbers
	function automatic logic [2:0] nextMenu(input logic [2:0] m, input logic up, input logic [1:0] lim,
		input logic rem);
		logic [2:0] n;
		logic found;
		n = m;
		found = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (!found) begin
				if (up) begin
					n = (n == `KP_MENU_COPY) ? `KP_MENU_FIRST : n + 3'h1;
				end else begin
					n = (n == `KP_MENU_FIRST) ? `KP_MENU_COPY : n - 3'h1;
				end
				found = menuAllowed(n, lim, rem);
			end
		end
		return found ? n : m;
	endfunction

	// Keep the remembered menu if still legal, else fall to the first legal one
	function automatic logic [2:0] snapMenu(input logic [2:0] m, input logic [1:0] lim, input logic rem);
		logic [2:0] f;
		f = (lim == `KP_LIMIT_CHECK) ? `KP_MENU_CHECK : `KP_MENU_FIRST;
		return menuAllowed(m, lim, rem) ? m : f;
	endfunction

	// Combination counts only while stop is already held
	assign combo = stopKeyHeld && functionDataKey;

	// Mode transitions; a new alarm overrides every key
	always_comb begin
		nxt_state = state_ff;
		releaseHit = 1'b0;
		unique case (state_ff)
			keypad_mode_pkg::ST_RUNNING: begin
				if (programResetKey) begin
					nxt_state = keypad_mode_pkg::ST_PROG_MENU;
				end
			end
			keypad_mode_pkg::ST_PROG_MENU: begin
				if (programResetKey) begin
					// An unreset alarm takes the display back to its code
					nxt_state = alarmActive_ff ? keypad_mode_pkg::ST_ALARM_CODE : keypad_mode_pkg::ST_RUNNING;
				end else if (functionDataKey && menu_ff == `KP_MENU_ALARM) begin
					nxt_state = keypad_mode_pkg::ST_PROG_HIST;
				end
			end
			keypad_mode_pkg::ST_PROG_HIST: begin
				if (programResetKey || functionDataKey) begin
					nxt_state = keypad_mode_pkg::ST_PROG_MENU;
				end
			end
			keypad_mode_pkg::ST_ALARM_CODE: begin
				if (combo) begin
					nxt_state = keypad_mode_pkg::ST_PROG_MENU;
				end else if (functionDataKey) begin
					nxt_state = keypad_mode_pkg::ST_ALARM_INFO;
				end else if (programResetKey && !alarmCauseActive) begin
					nxt_state = keypad_mode_pkg::ST_RUNNING;
					releaseHit = !alarmRaise;
				end
			end
			keypad_mode_pkg::ST_ALARM_INFO: begin
				if (combo) begin
					nxt_state = keypad_mode_pkg::ST_PROG_MENU;
				end else if (functionDataKey || programResetKey) begin
					nxt_state = keypad_mode_pkg::ST_ALARM_CODE;
				end
			end
		endcase
		if (alarmRaise) begin
			nxt_state = keypad_mode_pkg::ST_ALARM_CODE;
		end
	end

	// Coming back from the history view snaps too, so a limit changed there never shows a forbidden menu
	assign enterProg = state_ff != keypad_mode_pkg::ST_PROG_MENU && nxt_state == keypad_mode_pkg::ST_PROG_MENU;

	// State and the registered operation mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= keypad_mode_pkg::ST_RUNNING;
			opMode_ff <= keypad_mode_pkg::MODE_RUNNING;
		end else if (clkEn) begin
			state_ff <= nxt_state;
			unique case (nxt_state)
				keypad_mode_pkg::ST_RUNNING: opMode_ff <= keypad_mode_pkg::MODE_RUNNING;
				keypad_mode_pkg::ST_PROG_MENU,
				keypad_mode_pkg::ST_PROG_HIST: opMode_ff <= keypad_mode_pkg::MODE_PROGRAM;
				keypad_mode_pkg::ST_ALARM_CODE,
				keypad_mode_pkg::ST_ALARM_INFO: opMode_ff <= keypad_mode_pkg::MODE_ALARM;
			endcase
		end
	end

	// Alarm status: a raise wins over a release in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			alarmActive_ff <= 1'b0;
			alarmRelease_ff <= 1'b0;
		end else if (clkEn) begin
			alarmRelease_ff <= releaseHit;
			if (alarmRaise) begin
				alarmActive_ff <= 1'b1;
			end else if (releaseHit) begin
				alarmActive_ff <= 1'b0;
			end
		end
	end

	// Menu selection survives leaving Programming mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			menu_ff <= `KP_MENU_RESET;
		end else if (clkEn) begin
			if (enterProg) begin
				menu_ff <= snapMenu(menu_ff, menuLimitSetting, remoteKeypadReady);
			end else if (state_ff == keypad_mode_pkg::ST_PROG_MENU && nxt_state == state_ff) begin
				if (upKey || downKey) begin
					menu_ff <= nextMenu(menu_ff, upKey, menuLimitSetting, remoteKeypadReady);
				end else begin
					// A limit change while browsing must not leave a forbidden menu up
					menu_ff <= snapMenu(menu_ff, menuLimitSetting, remoteKeypadReady);
				end
			end
		end
	end

	// Alarm age and running information item under up/down
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			alarmIdx_ff <= `KP_IDX_RESET;
			infoItem_ff <= `KP_IDX_RESET;
		end else if (clkEn) begin
			if (alarmRaise || nxt_state != state_ff) begin
				// Every new view starts at item zero; the alarm age resets too, except between the alarm code and info views when no new alarm comes
				if (nxt_state != keypad_mode_pkg::ST_ALARM_INFO && nxt_state != keypad_mode_pkg::ST_ALARM_CODE) begin
					alarmIdx_ff <= `KP_IDX_RESET;
				end else if (alarmRaise) begin
					alarmIdx_ff <= `KP_IDX_RESET;
				end
				infoItem_ff <= `KP_IDX_RESET;
			end else if (state_ff == keypad_mode_pkg::ST_ALARM_CODE || state_ff == keypad_mode_pkg::ST_PROG_HIST) begin
				if (upKey) begin
					alarmIdx_ff <= alarmIdx_ff + 2'h1;
				end else if (downKey) begin
					alarmIdx_ff <= alarmIdx_ff - 2'h1;
				end
			end else if (state_ff == keypad_mode_pkg::ST_ALARM_INFO) begin
				if (upKey) begin
					infoItem_ff <= infoItem_ff + 2'h1;
				end else if (downKey) begin
					infoItem_ff <= infoItem_ff - 2'h1;
				end
			end
		end
	end

	// Alternation between item number and data; restarts on every view change
	assign altRun = nxt_state == state_ff && (state_ff == keypad_mode_pkg::ST_ALARM_INFO
		|| state_ff == keypad_mode_pkg::ST_PROG_HIST);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			altCnt_ff <= 32'h0;
			showData_ff <= 1'b0;
		end else if (clkEn) begin
			if (!altRun || upKey || downKey) begin
				altCnt_ff <= 32'h0;
				showData_ff <= 1'b0;
			end else if (altCnt_ff == ALT_CYCLES - 32'h1) begin
				altCnt_ff <= 32'h0;
				showData_ff <= !showData_ff;
			end else begin
				altCnt_ff <= altCnt_ff + 32'h1;
			end
		end
	end

	// History store: active alarm plus three earlier ones
	assign hist.wrEn = alarmRaise && clkEn;
	assign hist.wrCode = alarmCode;
	assign hist.wrInfo = runInfoSnap;
	assign hist.rdAge = alarmIdx_ff;

	alarm_history_mem histMem (
		.clk(clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.hist(hist.store)
	);

	// What the display shows in each state
	always_comb begin
		selNow = keypad_mode_pkg::DISP_RUNNING;
		unique case (state_ff)
			keypad_mode_pkg::ST_RUNNING: selNow = keypad_mode_pkg::DISP_RUNNING;
			keypad_mode_pkg::ST_PROG_MENU: selNow = keypad_mode_pkg::DISP_MENU;
			keypad_mode_pkg::ST_PROG_HIST:
				selNow = showData_ff ? keypad_mode_pkg::DISP_INFO_DATA : keypad_mode_pkg::DISP_HIST_CODE;
			keypad_mode_pkg::ST_ALARM_CODE: selNow = keypad_mode_pkg::DISP_ALARM_CODE;
			keypad_mode_pkg::ST_ALARM_INFO:
				selNow = showData_ff ? keypad_mode_pkg::DISP_INFO_DATA : keypad_mode_pkg::DISP_INFO_NUM;
		endcase
	end

	// Display data; the menu number lands in the leftmost digit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dispSel_ff <= keypad_mode_pkg::DISP_RUNNING;
			dispData_ff <= 16'h0000;
			changedOnly_ff <= 1'b0;
		end else if (clkEn) begin
			dispSel_ff <= selNow;
			changedOnly_ff <= state_ff == keypad_mode_pkg::ST_PROG_MENU && menu_ff == `KP_MENU_CHECK;
			unique case (selNow)
				keypad_mode_pkg::DISP_MENU: dispData_ff <= {1'b0, menu_ff, 12'h000};
				keypad_mode_pkg::DISP_ALARM_CODE,
				keypad_mode_pkg::DISP_HIST_CODE: dispData_ff <= {8'h00, hist.rdCode};
				keypad_mode_pkg::DISP_INFO_NUM: dispData_ff <= {14'h0000, infoItem_ff};
				keypad_mode_pkg::DISP_INFO_DATA: dispData_ff <= hist.rdInfo[{infoItem_ff, 4'h0} +: 16];
				keypad_mode_pkg::DISP_RUNNING: dispData_ff <= 16'h0000;
				default: dispData_ff <= 16'h0000;
			endcase
		end
	end

	assign opMode = opMode_ff;
	assign dispSel = dispSel_ff;
	assign menuNumber = menu_ff;
	assign alarmIndex = alarmIdx_ff;
	assign infoItem = infoItem_ff;
	assign dispData = dispData_ff;
	assign changedOnly = changedOnly_ff;
	assign alarmPending = alarmActive_ff;
	assign alarmRelease = alarmRelease_ff;

	// Checks on the mode behaviour
	a_reset_running: assert property (
		@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> opMode_ff == keypad_mode_pkg::MODE_RUNNING && !alarmActive_ff
	) else $error("Not in Running mode after reset");

	a_alarm_entry: assert property (
		@(posedge clk) disable iff (!reset_n)
		clkEn && alarmRaise ##1 clkEn |-> opMode_ff == keypad_mode_pkg::MODE_ALARM
			##1 dispSel_ff == keypad_mode_pkg::DISP_ALARM_CODE
	) else $error("Alarm did not bring up the alarm code");

	a_menu_kept: assert property (
		@(posedge clk) disable iff (!reset_n)
		clkEn && enterProg && menuAllowed(menu_ff, menuLimitSetting, remoteKeypadReady) |=> menu_ff == $past(menu_ff)
	) else $error("Last menu not restored on entry");

	a_menu_legal: assert property (
		@(posedge clk) disable iff (!reset_n)
		state_ff == keypad_mode_pkg::ST_PROG_MENU && $past(clkEn) && $stable(menuLimitSetting)
			&& $stable(remoteKeypadReady) |-> menuAllowed(menu_ff, menuLimitSetting, remoteKeypadReady)
	) else $error("Menu outside the limit");

	a_default_one: assert property (
		@(posedge clk) disable iff (!reset_n)
		state_ff == keypad_mode_pkg::ST_PROG_MENU && menuLimitSetting == `KP_LIMIT_SET
			&& $past(menuLimitSetting) == `KP_LIMIT_SET && $past(clkEn) |-> menu_ff == `KP_MENU_FIRST
	) else $error("Menu other than one under default limit");

	a_menu_wrap: assert property (
		@(posedge clk) disable iff (!reset_n)
		clkEn && state_ff == keypad_mode_pkg::ST_PROG_MENU && upKey && !programResetKey && !functionDataKey
			&& !alarmRaise && menuLimitSetting == `KP_LIMIT_FULL && !remoteKeypadReady
			&& menu_ff == `KP_MENU_ALARM |=> menu_ff == `KP_MENU_FIRST
	) else $error("Menu did not wrap to the first");

	a_release_at_code: assert property (
		@(posedge clk) disable iff (!reset_n)
		alarmRelease_ff && $past(clkEn) |-> $past(state_ff) == keypad_mode_pkg::ST_ALARM_CODE
			&& !$past(alarmCauseActive) && state_ff == keypad_mode_pkg::ST_RUNNING
	) else $error("Alarm released away from the code display");

	a_info_first_press: assert property (
		@(posedge clk) disable iff (!reset_n)
		clkEn && state_ff == keypad_mode_pkg::ST_ALARM_INFO && programResetKey && !stopKeyHeld && !alarmRaise
			|=> state_ff == keypad_mode_pkg::ST_ALARM_CODE && !alarmRelease_ff && alarmActive_ff
	) else $error("First reset press left info view wrongly");

	a_combo_unreset: assert property (
		@(posedge clk) disable iff (!reset_n)
		clkEn && state_ff == keypad_mode_pkg::ST_ALARM_CODE && combo && !alarmRaise
			|=> opMode_ff == keypad_mode_pkg::MODE_PROGRAM && alarmActive_ff && !alarmRelease_ff
	) else $error("Combination entry reset the alarm");

	a_info_alternate: assert property (
		@(posedge clk) disable iff (!reset_n)
		state_ff == keypad_mode_pkg::ST_ALARM_INFO && $past(state_ff) == keypad_mode_pkg::ST_ALARM_INFO
			&& $rose(showData_ff) |-> $past(altCnt_ff) == ALT_CYCLES - 32'h1
	) else $error("Item data shown before the alternation time");

endmodule // keypad_operation_mode_fsm

//--- test/keypad_panel_model.sv
/*
 Operator keypad model: issues key presses as one-cycle pulses and holds
 the stop key as a level for combinations.
 Assumes the bench calls press between clock edges, one press at a time.
*/
`timescale 1ns/1ns
module keypad_panel_model (
	// Clock
	input wire logic clk,
	// Keys towards the controller
	output logic programResetKey,
	output logic functionDataKey,
	output logic upKey,
	output logic downKey,
	output logic stopKeyHeld
);
	// Keys start released so the controller never sees an unknown press
	initial begin
		programResetKey = 1'b0;
		functionDataKey = 1'b0;
		upKey = 1'b0;
		downKey = 1'b0;
		stopKeyHeld = 1'b0;
	end

	// One press: raised just after an edge, dropped just after the next
	task automatic press(input int unsigned keyId, input logic withStop);
		@(posedge clk);
		#1;
		stopKeyHeld = withStop;
		case (keyId)
			0: programResetKey = 1'b1;
			1: functionDataKey = 1'b1;
			2: upKey = 1'b1;
			default: downKey = 1'b1;
		endcase
		@(posedge clk);
		#1;
		{programResetKey, functionDataKey, upKey, downKey} = 4'h0;
		stopKeyHeld = 1'b0;
	endtask
endmodule // keypad_panel_model

//--- test/keypad_operation_mode_fsm_tb_top.sv
/*
 Self-checking bench of the keypad operation mode controller: menus under
 the menu limit, alarm release, history, running information, combination.
 Assumes a short alternation count and a keypad model driving the keys.
*/
`timescale 1ns/1ns
module keypad_operation_mode_fsm_tb_top;
	// Clock, reset and protective function side
	logic clk, reset_n, clkEn, alarmRaise, alarmCauseActive, remoteKeypadReady;
	logic [7:0] alarmCode;
	logic [63:0] runInfoSnap;
	logic [1:0] menuLimitSetting;
	// Keys and outputs
	logic programResetKey, functionDataKey, upKey, downKey, stopKeyHeld, changedOnly, alarmPending, alarmRelease;
	keypad_mode_pkg::opMode_e opMode;
	keypad_mode_pkg::dispSel_e dispSel;
	logic [2:0] menuNumber, expMenu;
	logic [1:0] alarmIndex, infoItem;
	logic [15:0] dispData;
	logic [7:0] codes [4];
	logic [63:0] snap;
	int errTotal = 0;
	int samplesChecked = 0;
	int unsigned i, k;
	logic dirUp;

	// Short alternation keeps the run brief
	keypad_operation_mode_fsm #(.ALT_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
		.programResetKey(programResetKey), .functionDataKey(functionDataKey), .upKey(upKey),
		.downKey(downKey), .stopKeyHeld(stopKeyHeld), .alarmRaise(alarmRaise), .alarmCode(alarmCode),
		.alarmCauseActive(alarmCauseActive), .runInfoSnap(runInfoSnap), .menuLimitSetting(menuLimitSetting),
		.remoteKeypadReady(remoteKeypadReady), .opMode(opMode), .dispSel(dispSel), .menuNumber(menuNumber),
		.alarmIndex(alarmIndex), .infoItem(infoItem), .dispData(dispData), .changedOnly(changedOnly),
		.alarmPending(alarmPending), .alarmRelease(alarmRelease));

	keypad_panel_model kp (.clk(clk), .programResetKey(programResetKey), .functionDataKey(functionDataKey),
		.upKey(upKey), .downKey(downKey), .stopKeyHeld(stopKeyHeld));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Comparison with counting and immediate report
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Alarm pulse; code and snapshot go stale right after so a late sample shows
	task automatic raise(input logic [7:0] code, input logic [63:0] info);
		@(posedge clk);
		#1;
		alarmRaise = 1'b1;
		alarmCode = code;
		runInfoSnap = info;
		@(posedge clk);
		#1;
		alarmRaise = 1'b0;
		alarmCode = ~code;
		runInfoSnap = ~info;
	endtask

	// Bounded wait for the data half of the alternation
	task automatic waitData();
		int n;
		n = 0;
		while (dispSel !== keypad_mode_pkg::DISP_INFO_DATA && n < 20) begin
			settle(1);
			n++;
		end
	endtask

	// Expected next menu in full-menu mode
	function automatic logic [2:0] stepMenu(input logic [2:0] m, input logic up, input logic rem);
		logic [2:0] top;
		top = rem ? 3'h7 : 3'h6;
		if (up) stepMenu = (m >= top) ? 3'h1 : m + 3'h1;
		else stepMenu = (m == 3'h1) ? top : m - 3'h1;
	endfunction

	task automatic finalReport();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#200000;
		errTotal++;
		finalReport();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h7F82716B));
		reset_n = 1'b0;
		clkEn = 1'b1;
		alarmRaise = 1'b0;
		alarmCode = 8'h00;
		runInfoSnap = 64'h0;
		alarmCauseActive = 1'b0;
		menuLimitSetting = 2'h0;
		remoteKeypadReady = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		reset_n = 1'b1;
		settle(2);
		check(opMode, keypad_mode_pkg::MODE_RUNNING);
		check({dispSel, menuNumber, alarmPending}, {keypad_mode_pkg::DISP_RUNNING, 3'h1, 1'b0});
		$display("test reset done");

		// Limit 0: only menu one, steps refused
		kp.press(0, 1'b0);
		kp.press(2, 1'b0);
		settle(3);
		check({opMode, menuNumber, dispData[15:12]}, {keypad_mode_pkg::MODE_PROGRAM, 3'h1, 4'h1});
		kp.press(0, 1'b0);
		settle(1);
		check(opMode, keypad_mode_pkg::MODE_RUNNING);
		// Limit 1: data checking menu lists changed codes
		menuLimitSetting = 2'h1;
		kp.press(0, 1'b0);
		kp.press(3, 1'b0);
		settle(3);
		check({menuNumber, changedOnly, dispData[15:12]}, {3'h2, 1'b1, 4'h2});
		kp.press(0, 1'b0);
		// Full menu: re-entry keeps menu two, then random stepping with wrap
		menuLimitSetting = 2'h2;
		remoteKeypadReady = 1'($urandom % 2);
		kp.press(0, 1'b0);
		settle(1);
		check(menuNumber, 3'h2);
		expMenu = 3'h2;
		for (i = 0; i < 12; i++) begin
			dirUp = 1'($urandom % 2);
			if (i < 6) dirUp = 1'b1;
			kp.press(dirUp ? 2 : 3, 1'b0);
			expMenu = stepMenu(expMenu, dirUp, remoteKeypadReady);
			settle(2);
			check({menuNumber, dispData[15:12]}, {expMenu, 1'b0, expMenu});
		end
		kp.press(0, 1'b0);
		kp.press(0, 1'b0);
		settle(1);
		check(menuNumber, expMenu);
		kp.press(0, 1'b0);
		$display("test menus done");

		// Four alarms, the first three released at the code display
		for (i = 0; i < 4; i++) begin
			codes[i] = 8'($urandom);
			snap = {$urandom, $urandom};
			raise(codes[i], snap);
			settle(3);
			check({opMode, alarmPending, dispData}, {keypad_mode_pkg::MODE_ALARM, 1'b1, 8'h00, codes[i]});
			if (i < 3) begin
				kp.press(0, 1'b0);
				check({opMode, alarmRelease, alarmPending}, {keypad_mode_pkg::MODE_RUNNING, 2'b10});
				settle(1);
				check(alarmRelease, 1'b0);
			end
		end
		// History browse, newest first, four ups wrap home
		for (i = 1; i < 5; i++) begin
			kp.press(2, 1'b0);
			settle(3);
			check({alarmIndex, dispData}, {2'(i), 8'h00, codes[(3 - i) % 4]});
		end
		// Cause still present: release refused
		alarmCauseActive = 1'b1;
		kp.press(0, 1'b0);
		settle(1);
		check({opMode, alarmPending}, {keypad_mode_pkg::MODE_ALARM, 1'b1});
		// Running information items at the alarm
		kp.press(1, 1'b0);
		waitData();
		check({infoItem, dispData}, {2'h0, snap[15:0]});
		kp.press(2, 1'b0);
		settle(1);
		waitData();
		check({infoItem, dispData}, {2'h1, snap[31:16]});
		kp.press(1, 1'b0);
		settle(2);
		check(dispSel, keypad_mode_pkg::DISP_ALARM_CODE);
		// Cause gone: first press back to code, second releases
		alarmCauseActive = 1'b0;
		kp.press(1, 1'b0);
		kp.press(0, 1'b0);
		settle(2);
		check({opMode, alarmPending, dispSel}, {keypad_mode_pkg::MODE_ALARM, 1'b1, keypad_mode_pkg::DISP_ALARM_CODE});
		kp.press(0, 1'b0);
		check({opMode, alarmRelease}, {keypad_mode_pkg::MODE_RUNNING, 1'b1});
		$display("test alarms done");

		// Alarm while programming, then stop plus function keeps it pending
		kp.press(0, 1'b0);
		raise(8'h5A, 64'h0);
		settle(1);
		check(opMode, keypad_mode_pkg::MODE_ALARM);
		kp.press(1, 1'b1);
		settle(1);
		check({opMode, alarmPending, alarmRelease}, {keypad_mode_pkg::MODE_PROGRAM, 2'b10});
		kp.press(0, 1'b0);
		settle(2);
		check({opMode, dispSel}, {keypad_mode_pkg::MODE_ALARM, keypad_mode_pkg::DISP_ALARM_CODE});
		kp.press(0, 1'b0);
		check({opMode, alarmPending}, {keypad_mode_pkg::MODE_RUNNING, 1'b0});
		$display("test combination done");

		// Menu six opens the history from Programming mode, newest first
		kp.press(0, 1'b0);
		for (k = 0; k < 8 && menuNumber !== 3'h6; k++) begin
			kp.press(2, 1'b0);
		end
		check(menuNumber, 3'h6);
		kp.press(1, 1'b0);
		settle(2);
		check({dispSel, dispData}, {keypad_mode_pkg::DISP_HIST_CODE, 16'h005A});
		kp.press(2, 1'b0);
		settle(3);
		check({alarmIndex, dispData}, {2'h1, 8'h00, codes[3]});
		kp.press(1, 1'b0);
		kp.press(0, 1'b0);
		settle(1);
		check(opMode, keypad_mode_pkg::MODE_RUNNING);
		$display("test history menu done");

		// Clock enable low freezes all state, so this press is lost
		clkEn = 1'b0;
		kp.press(0, 1'b0);
		settle(2);
		check({opMode, menuNumber}, {keypad_mode_pkg::MODE_RUNNING, 3'h6});
		clkEn = 1'b1;
		kp.press(0, 1'b0);
		check({opMode, menuNumber}, {keypad_mode_pkg::MODE_PROGRAM, 3'h6});
		// A reset in mid-run lands in Running mode with menu one
		reset_n = 1'b0;
		settle(2);
		reset_n = 1'b1;
		settle(2);
		check({opMode, dispSel, menuNumber, alarmPending},
			{keypad_mode_pkg::MODE_RUNNING, keypad_mode_pkg::DISP_RUNNING, 3'h1, 1'b0});
		$display("test clock enable and reset done");
		finalReport();
	end
endmodule // keypad_operation_mode_fsm_tb_top
